// ---- src/rwsu_pkg.sv ----
// Purpose: shared constants for the module register control word loader
// Assumes: one controller clock, word data carried in the low bits of an 8-bit value
// Notes: ddr3 nibble = {bank1, bank0, data4, data3}; ddr4 nibble = data[3:0]
package rwsu_pkg;

    // ----------------------------------------------------------------
    // word numbering
    // ----------------------------------------------------------------
    localparam logic [4:0] DDR3_LAST_WORD = 5'h0f;
    localparam logic [4:0] DDR4_LAST_WORD = 5'h11;
    localparam logic [4:0] CA_DRIVE_WORD = 5'h03;
    localparam logic [4:0] CTL_DRIVE_WORD = 5'h04;
    localparam logic [4:0] CLK_DRIVE_WORD = 5'h05;
    localparam logic [4:0] DDR3_SPEED_WORD = 5'h0a;
    localparam logic [4:0] DDR3_VOLTAGE_WORD = 5'h0b;
    localparam logic [4:0] DDR4_RANK_HEIGHT_WORD = 5'h08;
    localparam logic [4:0] DDR4_SPEED_WORD = 5'h0a;
    localparam logic [4:0] DDR4_VREF_WORD = 5'h0b;
    localparam logic [4:0] DDR4_CS_MODE_WORD = 5'h0d;
    localparam logic [4:0] DDR4_SIDEBAND_WORD = 5'h10;
    localparam logic [4:0] DDR4_FINE_SPEED_WORD = 5'h11;

    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int DDR4_ADDR_WIDTH_BIT = 3;
    localparam int DDR4_VREF_SRC_BIT = 3;
    localparam int DDR4_MODULE_TYPE_BIT = 2;
    localparam int DDR4_SIDEBAND_OFF_BIT = 0;
    localparam logic [1:0] RANK_FOUR = 2'h1;
    localparam logic [1:0] RANK_ONE_TWO = 2'h3;
    localparam logic [1:0] HEIGHT_1 = 2'h3;
    localparam logic [1:0] HEIGHT_2 = 2'h2;
    localparam logic [1:0] HEIGHT_4 = 2'h1;
    localparam logic [1:0] CS_QUAD = 2'h1;
    localparam logic [1:0] CS_DUAL = 2'h0;
    localparam logic [7:0] WORD_RESET = 8'h00;

    // ----------------------------------------------------------------
    // drive strength by load count
    // ----------------------------------------------------------------
    localparam logic [4:0] LIGHT_LOAD_MAX = 5'h04;
    localparam logic [4:0] MEDIUM_LOAD_MAX = 5'h09;
    localparam logic [3:0] DRIVE_LIGHT = 4'h0;
    localparam logic [3:0] DRIVE_MEDIUM = 4'h5;
    localparam logic [3:0] DRIVE_HEAVY = 4'ha;

    typedef enum logic [1:0] {
        RWSU_IDLE = 2'b00,
        RWSU_LATCH = 2'b01,
        RWSU_SEND = 2'b10,
        RWSU_DONE = 2'b11
    } rwsu_state_type;

endpackage

// ---- src/rwsu_cfg_latch.sv ----
// Purpose: holds the module description steady while the words are sent
// Assumes: inputs come from logic on sys_clk
// Notes: captured once per initialization
`timescale 1ns/1ps
module rwsu_cfg_latch (
    input wire logic sys_clk, // controller clock
    input wire logic rst, // synchronous reset
    input wire logic capture, // take the inputs
    input wire logic in_ddr4, // 1 = ddr4 module
    input wire logic [4:0] in_loads, // dram loads on card
    input wire logic [2:0] in_speed, // speed code
    input wire logic [7:0] in_fine_speed, // ddr4 fine speed code
    input wire logic [1:0] in_voltage, // ddr3 voltage code
    input wire logic [2:0] in_ranks, // ranks per slot
    input wire logic in_stacked, // stacked dies present
    input wire logic [2:0] in_height, // stack height
    input wire logic in_addr17, // 17 address pins
    input wire logic in_lrdimm, // load reduced module
    output logic ddr4, // held copies
    output logic [4:0] loads, // held
    output logic [2:0] speed, // held
    output logic [7:0] fine_speed, // held
    output logic [1:0] voltage, // held
    output logic [2:0] ranks, // held
    output logic stacked, // held
    output logic [2:0] height, // held
    output logic addr17, // held
    output logic lrdimm // held
);
    logic [27:0] held;
    logic [27:0] next_held;

    always_comb
    begin
        next_held = held;
        if (capture)
        begin
            next_held = {in_ddr4, in_loads, in_speed, in_fine_speed, in_voltage,
                         in_ranks, in_stacked, in_height, in_addr17, in_lrdimm};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            held <= 28'h0000000;
        else
            held <= next_held;
    end

    assign {ddr4, loads, speed, fine_speed, voltage, ranks, stacked, height, addr17,
            lrdimm} = held;
endmodule

// ---- src/rwsu_word_value.sv ----
// Purpose: value of one register-chip control word from the module description
// Assumes: combinational, fed from held configuration
// Notes: unlisted words are zero
`timescale 1ns/1ps
module rwsu_word_value (
    input wire logic [4:0] index, // control word number
    input wire logic ddr4, // 1 = ddr4 module
    input wire logic [4:0] loads, // dram loads
    input wire logic [2:0] speed, // speed code
    input wire logic [7:0] fine_speed, // fine speed code
    input wire logic [1:0] voltage, // voltage code
    input wire logic [2:0] ranks, // ranks per slot
    input wire logic stacked, // stacked dies
    input wire logic [2:0] height, // stack height
    input wire logic addr17, // 17 address pins
    input wire logic lrdimm, // load reduced module
    output logic [7:0] value // word data
);
    logic [3:0] drive;
    logic [1:0] rank_field;

    always_comb
    begin
        if (loads <= rwsu_pkg::LIGHT_LOAD_MAX)
            drive = rwsu_pkg::DRIVE_LIGHT;
        else if (loads <= rwsu_pkg::MEDIUM_LOAD_MAX)
            drive = rwsu_pkg::DRIVE_MEDIUM;
        else
            drive = rwsu_pkg::DRIVE_HEAVY;
        if (!stacked)
            rank_field = (ranks == 3'h4) ? rwsu_pkg::RANK_FOUR : rwsu_pkg::RANK_ONE_TWO;
        else if (height == 3'h4)
            rank_field = rwsu_pkg::HEIGHT_4;
        else if (height == 3'h2)
            rank_field = rwsu_pkg::HEIGHT_2;
        else
            rank_field = rwsu_pkg::HEIGHT_1;
        value = rwsu_pkg::WORD_RESET;
        if (!ddr4)
        begin
            case (index)
                rwsu_pkg::CA_DRIVE_WORD,
                rwsu_pkg::CTL_DRIVE_WORD,
                rwsu_pkg::CLK_DRIVE_WORD: value = {4'h0, drive};
                rwsu_pkg::DDR3_SPEED_WORD: value = {5'h00, speed};
                rwsu_pkg::DDR3_VOLTAGE_WORD: value = {6'h00, voltage};
                default: value = rwsu_pkg::WORD_RESET;
            endcase
        end
        else
        begin
            case (index)
                rwsu_pkg::CA_DRIVE_WORD,
                rwsu_pkg::CTL_DRIVE_WORD,
                rwsu_pkg::CLK_DRIVE_WORD: value = {4'h0, drive};
                rwsu_pkg::DDR4_RANK_HEIGHT_WORD:
                begin
                    value = {6'h00, rank_field};
                    value[rwsu_pkg::DDR4_ADDR_WIDTH_BIT] = addr17;
                end
                rwsu_pkg::DDR4_SPEED_WORD: value = {5'h00, speed};
                rwsu_pkg::DDR4_VREF_WORD: value[rwsu_pkg::DDR4_VREF_SRC_BIT] = 1'b1;
                rwsu_pkg::DDR4_CS_MODE_WORD:
                begin
                    value = {6'h00, (ranks == 3'h4) ? rwsu_pkg::CS_QUAD : rwsu_pkg::CS_DUAL};
                    value[rwsu_pkg::DDR4_MODULE_TYPE_BIT] = !lrdimm;
                end
                rwsu_pkg::DDR4_SIDEBAND_WORD:
                    value[rwsu_pkg::DDR4_SIDEBAND_OFF_BIT] = 1'b1;
                rwsu_pkg::DDR4_FINE_SPEED_WORD: value = fine_speed;
                default: value = rwsu_pkg::WORD_RESET;
            endcase
        end
    end
endmodule

// ---- src/rwsu_loader.sv ----
// Purpose: writes every register-chip control word of a registered memory module after reset
// Assumes: downstream command engine takes one word per valid/ready handshake
// Notes: normal traffic is held off until all words are taken
//
// Operation
// - ddr3 unlisted words are written zero
// - ddr4 unlisted words are written zero
// - drive words follow dram load count
// - speed words follow targeted speed
// - ddr3 voltage word follows targeted voltage
// - ddr4 rank/height field encodes ranks or height
// - ddr4 address width bit: 1 for 17
// - ddr4 reference source bit written one
// - ddr4 chip select: quad for four ranks
// - ddr4 module bit: 0 lrdimm, 1 rdimm
// - ddr4 sideband bit one disables i2c
`timescale 1ns/1ps
module rwsu_loader (
    input wire logic sys_clk, // controller clock
    input wire logic rst, // synchronous reset, high
    input wire logic cfg_ddr4, // 1 = ddr4 module, 0 = ddr3
    input wire logic [4:0] cfg_loads, // dram loads on card
    input wire logic [2:0] cfg_speed, // targeted speed code
    input wire logic [7:0] cfg_fine_speed, // ddr4 fine speed code
    input wire logic [1:0] cfg_voltage, // ddr3 targeted voltage code
    input wire logic [2:0] cfg_ranks, // physical ranks per slot
    input wire logic cfg_stacked, // stacked dies present
    input wire logic [2:0] cfg_height, // stack height 1, 2 or 4
    input wire logic cfg_addr17, // module uses 17 address pins
    input wire logic cfg_lrdimm, // load reduced module
    input wire logic word_ready, // command engine takes the word
    output logic word_valid, // a control word is offered
    output logic [4:0] word_index, // control word number
    output logic [7:0] word_data, // control word value
    output logic traffic_enable // words done, normal traffic allowed
);
    // ----------------------------------------------------------------
    // held configuration and word values
    // ----------------------------------------------------------------
    rwsu_pkg::rwsu_state_type state;
    rwsu_pkg::rwsu_state_type next_state;
    logic next_word_valid;
    logic [4:0] next_word_index;
    logic [7:0] next_word_data;
    logic next_traffic_enable;
    logic h_ddr4;
    logic [4:0] h_loads;
    logic [2:0] h_speed;
    logic [7:0] h_fine_speed;
    logic [1:0] h_voltage;
    logic [2:0] h_ranks;
    logic h_stacked;
    logic [2:0] h_height;
    logic h_addr17;
    logic h_lrdimm;
    logic [4:0] value_index;
    logic [7:0] value;
    logic [4:0] last_word;
    logic taken;

    rwsu_cfg_latch u_cfg (
        .sys_clk(sys_clk),
        .rst(rst),
        .capture(state == rwsu_pkg::RWSU_IDLE),
        .in_ddr4(cfg_ddr4),
        .in_loads(cfg_loads),
        .in_speed(cfg_speed),
        .in_fine_speed(cfg_fine_speed),
        .in_voltage(cfg_voltage),
        .in_ranks(cfg_ranks),
        .in_stacked(cfg_stacked),
        .in_height(cfg_height),
        .in_addr17(cfg_addr17),
        .in_lrdimm(cfg_lrdimm),
        .ddr4(h_ddr4),
        .loads(h_loads),
        .speed(h_speed),
        .fine_speed(h_fine_speed),
        .voltage(h_voltage),
        .ranks(h_ranks),
        .stacked(h_stacked),
        .height(h_height),
        .addr17(h_addr17),
        .lrdimm(h_lrdimm)
    );

    rwsu_word_value u_value (
        .index(value_index),
        .ddr4(h_ddr4),
        .loads(h_loads),
        .speed(h_speed),
        .fine_speed(h_fine_speed),
        .voltage(h_voltage),
        .ranks(h_ranks),
        .stacked(h_stacked),
        .height(h_height),
        .addr17(h_addr17),
        .lrdimm(h_lrdimm),
        .value(value)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    assign last_word = h_ddr4 ? rwsu_pkg::DDR4_LAST_WORD : rwsu_pkg::DDR3_LAST_WORD;
    assign taken = word_valid && word_ready;

    always_comb
    begin
        next_state = state;
        next_word_valid = word_valid;
        next_word_index = word_index;
        next_traffic_enable = traffic_enable;
        value_index = word_index;
        case (state)
            rwsu_pkg::RWSU_IDLE:
                next_state = rwsu_pkg::RWSU_LATCH;
            rwsu_pkg::RWSU_LATCH:
            begin
                value_index = 5'h00;
                next_word_index = 5'h00;
                next_word_valid = 1'b1;
                next_state = rwsu_pkg::RWSU_SEND;
            end
            rwsu_pkg::RWSU_SEND:
            begin
                if (taken)
                begin
                    if (word_index == last_word)
                    begin
                        next_word_valid = 1'b0;
                        next_traffic_enable = 1'b1;
                        next_state = rwsu_pkg::RWSU_DONE;
                    end
                    else
                    begin
                        next_word_index = word_index + 5'h01;
                        value_index = word_index + 5'h01;
                    end
                end
            end
            rwsu_pkg::RWSU_DONE:
                next_traffic_enable = 1'b1;
            default:
                next_state = rwsu_pkg::RWSU_IDLE;
        endcase
        next_word_data = (next_word_valid) ? value : rwsu_pkg::WORD_RESET;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= rwsu_pkg::RWSU_IDLE;
            word_valid <= 1'b0;
            word_index <= 5'h00;
            word_data <= rwsu_pkg::WORD_RESET;
            traffic_enable <= 1'b0;
        end
        else
        begin
            state <= next_state;
            word_valid <= next_word_valid;
            word_index <= next_word_index;
            word_data <= next_word_data;
            traffic_enable <= next_traffic_enable;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_DDR3_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && !h_ddr4 && !(word_index inside {5'h03, 5'h04, 5'h05, 5'h0a, 5'h0b})
        |-> word_data == 8'h00)
        else $error("ddr3 unlisted word not zero");

    AST_DDR4_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && h_ddr4
        && !(word_index inside {5'h03, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h0b, 5'h0d, 5'h10, 5'h11})
        |-> word_data == 8'h00)
        else $error("ddr4 unlisted word not zero");

    AST_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && word_index inside {5'h03, 5'h04, 5'h05}
        |-> word_data == ((h_loads <= 5'h04) ? 8'h00 : (h_loads <= 5'h09) ? 8'h05 : 8'h0a))
        else $error("drive word does not follow load count");

    AST_SPEED: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && (word_index == 5'h0a || (h_ddr4 && word_index == 5'h11))
        |-> word_data == ((word_index == 5'h11) ? h_fine_speed : {5'h00, h_speed}))
        else $error("speed word mismatch");

    AST_VOLTAGE: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && !h_ddr4 && word_index == 5'h0b |-> word_data == {6'h00, h_voltage})
        else $error("ddr3 voltage word mismatch");

    AST_RANK_HEIGHT: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && h_ddr4 && word_index == 5'h08
        |-> word_data[1:0] == (!h_stacked ? ((h_ranks == 3'h4) ? 2'h1 : 2'h3)
                              : (h_height == 3'h4) ? 2'h1 : (h_height == 3'h2) ? 2'h2 : 2'h3))
        else $error("rank/height field mismatch");

    AST_ADDR_WIDTH: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && h_ddr4 && word_index == 5'h08 |-> word_data[3] == h_addr17)
        else $error("address width bit mismatch");

    AST_VREF: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && h_ddr4 && word_index == 5'h0b |-> word_data == 8'h08)
        else $error("reference source bit not set");

    AST_CS_MODE: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && h_ddr4 && word_index == 5'h0d
        |-> word_data[1:0] == ((h_ranks == 3'h4) ? 2'h1 : 2'h0))
        else $error("chip select mode mismatch");

    AST_MODULE_TYPE: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && h_ddr4 && word_index == 5'h0d |-> word_data[2] == !h_lrdimm)
        else $error("module type bit mismatch");

    AST_SIDEBAND: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && h_ddr4 && word_index == 5'h10 |-> word_data == 8'h01)
        else $error("sideband word not disabling i2c");

    // ----------------------------------------------------------------
    // stream order, held description and traffic gate
    // ----------------------------------------------------------------
    AST_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid && !word_ready |=> word_valid && $stable(word_index) && $stable(word_data))
        else $error("offered word dropped before taken");

    AST_TRAFFIC_AFTER_LAST: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(traffic_enable) |-> $past(taken) && $past(word_index) == last_word && !word_valid)
        else $error("traffic enabled before last word taken");

    AST_START: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(rst) |-> !word_valid ##1 !word_valid
        ##1 word_valid && word_index == 5'h00 && !traffic_enable)
        else $error("sequence did not start at word zero");

    // a taken word that is not the last is followed at once by its successor
    AST_INDEX_STEP: assert property (@(posedge sys_clk) disable iff (rst)
        taken && word_index != last_word
        |=> word_valid && word_index == $past(word_index) + 5'h01)
        else $error("word number did not step by one");

    AST_DATA_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
        !word_valid |-> word_data == 8'h00)
        else $error("word data not zero while no word offered");

    AST_VALID_GATED: assert property (@(posedge sys_clk) disable iff (rst)
        word_valid |-> !traffic_enable)
        else $error("traffic allowed while a word is still offered");

    // once open, the gate stays open until the next reset
    AST_TRAFFIC_STAYS: assert property (@(posedge sys_clk) disable iff (rst)
        traffic_enable |=> traffic_enable && !word_valid)
        else $error("traffic gate dropped or word offered after release");

    // later changes on the description pins must not reach the words
    AST_CFG_HELD: assert property (@(posedge sys_clk) disable iff (rst)
        state != rwsu_pkg::RWSU_IDLE
        |=> $stable(h_ddr4) && $stable(h_loads) && $stable(h_ranks) && $stable(h_lrdimm))
        else $error("module description changed during load");

endmodule

// ---- verification/rwsu_engine_model.sv ----
// Purpose: command engine that takes control words from the loader
// Assumes: one word per valid/ready handshake on sys_clk
// Notes: slow mode accepts only one cycle in three to stall the loader
`timescale 1ns/1ps
module rwsu_engine_model (
    input wire logic sys_clk, // controller clock
    input wire logic rst, // synchronous reset
    input wire logic slow, // 1 = stall between words
    input wire logic word_valid, // word offered
    input wire logic [4:0] word_index, // control word number
    input wire logic [7:0] word_data, // control word value
    output logic word_ready, // word taken this cycle
    output logic [7:0] got_data [0:31], // words taken, by number
    output logic [5:0] got_count, // words taken so far
    output logic proto_err // order broken or word changed while waiting
);
    logic [1:0] phase;
    logic held_valid;
    logic [12:0] held;
    int i;

    initial
    begin
        word_ready = 1'b0;
        phase = 2'h0;
        got_count = 6'h00;
        proto_err = 1'b0;
        held_valid = 1'b0;
        held = 13'h0000;
    end

    // ----------------------------------------------------------------
    // take words, check order and that a waiting word stands
    // ----------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            got_count <= 6'h00;
            proto_err <= 1'b0;
            held_valid <= 1'b0;
            for (i = 0; i < 32; i++)
                got_data[i] <= 8'hee;
        end
        else
        begin
            if (held_valid && ({word_valid, word_index, word_data} !== {1'b1, held}))
                proto_err <= 1'b1;
            held_valid <= word_valid && !word_ready;
            held <= {word_index, word_data};
            if (word_valid === 1'b1 && word_ready)
            begin
                if (word_index !== got_count[4:0])
                    proto_err <= 1'b1;
                got_data[word_index] <= word_data;
                got_count <= got_count + 6'h01;
            end
        end
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        #1 word_ready <= !slow || (phase == 2'h2);
    end
endmodule

// ---- verification/rwsu_loader_tb.sv ----
// Purpose: self-checking bench for the control word loader
// Assumes: inputs driven 1 ns after the rising edge
// Notes: expected words worked out here from the module description
`timescale 1ns/1ps
module rwsu_loader_tb;
    logic sys_clk, rst, slow, cfg_ddr4, cfg_stacked, cfg_addr17, cfg_lrdimm;
    logic [4:0] cfg_loads;
    logic [2:0] cfg_speed, cfg_ranks, cfg_height;
    logic [7:0] cfg_fine_speed;
    logic [1:0] cfg_voltage;
    logic word_ready, word_valid, traffic_enable, proto_err;
    logic [4:0] word_index;
    logic [7:0] word_data;
    logic [7:0] got_data [0:31];
    logic [5:0] got_count;
    int errors = 0;
    int samples_checked = 0;

    rwsu_loader i_dut (.sys_clk(sys_clk), .rst(rst), .cfg_ddr4(cfg_ddr4), .cfg_loads(cfg_loads),
        .cfg_speed(cfg_speed), .cfg_fine_speed(cfg_fine_speed), .cfg_voltage(cfg_voltage),
        .cfg_ranks(cfg_ranks), .cfg_stacked(cfg_stacked), .cfg_height(cfg_height),
        .cfg_addr17(cfg_addr17), .cfg_lrdimm(cfg_lrdimm), .word_ready(word_ready),
        .word_valid(word_valid), .word_index(word_index), .word_data(word_data),
        .traffic_enable(traffic_enable));
    rwsu_engine_model i_engine (.sys_clk(sys_clk), .rst(rst), .slow(slow),
        .word_valid(word_valid), .word_index(word_index), .word_data(word_data),
        .word_ready(word_ready), .got_data(got_data), .got_count(got_count),
        .proto_err(proto_err));

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // compare, verdict, expected word value
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [7:0] exp_word(input logic [4:0] i);
        logic [3:0] drv;
        logic [1:0] rh;
        drv = (cfg_loads <= 5'h04) ? 4'h0 : (cfg_loads <= 5'h09) ? 4'h5 : 4'ha;
        if (!cfg_stacked)
            rh = (cfg_ranks == 3'h4) ? 2'h1 : 2'h3;
        else
            rh = (cfg_height == 3'h2) ? 2'h2 : (cfg_height == 3'h4) ? 2'h1 : 2'h3;
        if (i >= 5'h03 && i <= 5'h05)
            return {4'h0, drv};
        if (i == 5'h0a)
            return {5'h00, cfg_speed};
        if (!cfg_ddr4)
            return (i == 5'h0b) ? {6'h00, cfg_voltage} : 8'h00;
        case (i)
            5'h08: return {4'h0, cfg_addr17, 1'b0, rh};
            5'h0b: return 8'h08;
            5'h0d: return {5'h00, !cfg_lrdimm, (cfg_ranks == 3'h4) ? 2'h1 : 2'h0};
            5'h10: return 8'h01;
            5'h11: return cfg_fine_speed;
            default: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // one initialization: reset, wait for release of traffic, compare
    // ----------------------------------------------------------------
    task automatic run(input bit disturb, input string name);
        logic [27:0] saved;
        int n;
        int k;
        n = cfg_ddr4 ? 18 : 16;
        rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        check({word_valid, traffic_enable, word_index}, 8'h00, "outputs in reset");
        check(word_data, 8'h00, "data in reset");
        rst = 1'b0;
        if (disturb)
        begin
            repeat (2) @(posedge sys_clk);
            #1;
            saved = {cfg_ddr4, cfg_loads, cfg_speed, cfg_fine_speed, cfg_voltage, cfg_ranks,
                cfg_stacked, cfg_height, cfg_addr17, cfg_lrdimm};
            {cfg_loads, cfg_speed, cfg_fine_speed, cfg_voltage, cfg_ranks, cfg_stacked,
                cfg_height, cfg_addr17, cfg_lrdimm} = ~saved[26:0];
        end
        for (k = 0; k < 300 && traffic_enable !== 1'b1; k++)
        begin
            @(posedge sys_clk);
            #1;
            check(traffic_enable, (got_count == n[5:0]), "traffic gate");
        end
        if (k == 300)
        begin
            errors++;
            $display("mismatch at %0t: %s never finished", $time, name);
            return;
        end
        if (disturb)
            {cfg_ddr4, cfg_loads, cfg_speed, cfg_fine_speed, cfg_voltage, cfg_ranks,
                cfg_stacked, cfg_height, cfg_addr17, cfg_lrdimm} = saved;
        check({2'h0, got_count}, n[7:0], "word count");
        check({word_valid, proto_err}, 8'h00, "stream end or order");
        check(word_data, 8'h00, "data after last word");
        for (k = 0; k < n; k++)
            check(got_data[k], exp_word(k[4:0]), "word value");
        for (k = 3; k <= 5; k++)
            check(got_data[k], exp_word(k[4:0]), "drive word");
        check(got_data[10], exp_word(5'h0a), "speed word");
        if (cfg_ddr4)
        begin
            check(got_data[17], cfg_fine_speed, "fine speed word");
            check(got_data[8], exp_word(5'h08), "rank height word");
            check(got_data[11], 8'h08, "reference word");
            check(got_data[13], exp_word(5'h0d), "chip select word");
            check(got_data[16], 8'h01, "sideband word");
        end
        else
            check(got_data[11], {6'h00, cfg_voltage}, "voltage word");
        $display("%s done at %0t", name, $time);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic set_cfg(input logic d4, input logic [4:0] ld, input logic [2:0] rk,
        input logic st, input logic [2:0] ht, input logic a17, input logic lr, input logic sl);
        {cfg_ddr4, cfg_loads, cfg_ranks, cfg_stacked, cfg_height} = {d4, ld, rk, st, ht};
        {cfg_addr17, cfg_lrdimm, slow} = {a17, lr, sl};
        cfg_speed = cfg_speed + 3'h3;
        cfg_fine_speed = cfg_fine_speed + 8'h5b;
        cfg_voltage = cfg_voltage + 2'h1;
    endtask

    task automatic test_ddr3_loads;
        logic [4:0] lds [0:4] = '{5'h04, 5'h05, 5'h09, 5'h0a, 5'h1f};
        int k;
        for (k = 0; k < 5; k++)
        begin
            set_cfg(1'b0, lds[k], 3'h2, 1'b0, 3'h1, 1'b0, 1'b0, k[0]);
            run(1'b0, "ddr3 loads");
        end
    endtask

    task automatic test_ddr4_ranks;
        set_cfg(1'b1, 5'h12, 3'h4, 1'b0, 3'h1, 1'b1, 1'b1, 1'b0);
        run(1'b0, "ddr4 quad lrdimm");
        set_cfg(1'b1, 5'h07, 3'h2, 1'b0, 3'h1, 1'b0, 1'b0, 1'b1);
        run(1'b0, "ddr4 dual rdimm");
        set_cfg(1'b1, 5'h02, 3'h1, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0);
        run(1'b0, "ddr4 single rank");
    endtask

    task automatic test_ddr4_stacked;
        logic [2:0] hts [0:3] = '{3'h1, 3'h2, 3'h4, 3'h4};
        int k;
        for (k = 0; k < 4; k++)
        begin
            set_cfg(1'b1, 5'h09, 3'h4, 1'b1, hts[k], k[0], k[1], 1'b1);
            run(1'b0, "ddr4 stacked");
        end
    endtask

    task automatic test_cfg_hold;
        set_cfg(1'b1, 5'h0a, 3'h2, 1'b0, 3'h1, 1'b1, 1'b0, 1'b1);
        run(1'b1, "config held");
        set_cfg(1'b0, 5'h03, 3'h4, 1'b1, 3'h2, 1'b0, 1'b1, 1'b0);
        run(1'b1, "ddr3 config held");
    endtask

    initial
    begin
        rst = 1'b1;
        slow = 1'b0;
        cfg_speed = 3'h0;
        cfg_fine_speed = 8'h00;
        cfg_voltage = 2'h0;
        set_cfg(1'b0, 5'h00, 3'h1, 1'b0, 3'h1, 1'b0, 1'b0, 1'b0);
        test_ddr3_loads();
        test_ddr4_ranks();
        test_ddr4_stacked();
        test_cfg_hold();
        print_verdict();
    end
endmodule
